// *** hw/srw_pkg.sv ***
// Constants shared by the system reset and watchdog block.
// Assumes a single 100 MHz core clock and pin-level inputs from analog detectors.
package srw_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Pulse-width filters, least times round up
  localparam int EXT_MIN_PULSE_NS = 2500;
  localparam int EXT_MIN_CYC = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BO_MIN_DUR_NS = 2000;
  localparam int BO_MIN_CYC = (BO_MIN_DUR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Reset delay counter
  localparam int DLY_W = 12;
  localparam int DLY_UNIT_CYC = 64;

  // Watchdog and brown-out off level
  localparam int WDT_OSC_HZ = 128000;
  localparam int WDT_BASE_TICKS = 2048;
  localparam int WDT_W = 20;
  localparam logic [3:0] WDT_PSEL_MAX = 4'h9;
  localparam int CE_WINDOW_CYC = 4;
  localparam logic [2:0] BO_LEVEL_OFF = 3'h7;

  // Reset cause flag positions
  localparam int FLG_POWER = 0;
  localparam int FLG_EXTRF = 1;
  localparam int FLG_BORF = 2;
  localparam int FLG_WDOG = 3;
  localparam logic [3:0] FLAGS_RST = 4'h1;

endpackage

// *** hw/srw_sync.sv ***
// Two-stage synchroniser for a vector of pin inputs.
// Assumes the inputs are asynchronous levels; no bit is a bus word.
module srw_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } srw_sync_t;

  srw_sync_t s_r, s_nxt;

  // First stage feeds only the second
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.s2;

endmodule // srw_sync

// *** hw/srw_filter.sv ***
// Minimum-duration filter: output rises after MIN_CYC consecutive high cycles.
// Assumes a synchronised input; output falls on the first low cycle.
module srw_filter #(
  parameter int MIN_CYC = 4,
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Level in and filtered level out
  input wire logic lvl,
  output logic filt
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic out;
  } srw_filt_t;

  srw_filt_t s_r, s_nxt;

  // Count consecutive active cycles
  always_comb begin
    s_nxt = s_r;
    if (!lvl) begin
      s_nxt.cnt = '0;
      s_nxt.out = 1'b0;
    end else if (s_r.cnt >= W'(MIN_CYC - 1)) begin
      s_nxt.out = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign filt = s_r.out;

endmodule // srw_filter

// *** hw/srw_reset_ctrl.sv ***
// Reset source merge, delay counter, reset cause flags and watchdog.
// Assumes analog detectors and fuses arrive as pins; core-side controls are on core_clk.
module srw_reset_ctrl
  import srw_pkg::*;
#(
  parameter int DLY_UNIT = DLY_UNIT_CYC,
  parameter int WDT_BASE = WDT_BASE_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Analog detectors and reset pin
  input wire logic supply_below_por,
  input wire logic reset_pin_n,
  input wire logic ext_reset_enable,
  input wire logic vcc_below_bot_minus,
  input wire logic vcc_above_bot_plus,
  input wire logic wdt_osc_clk,
  // Fuses
  input wire logic [2:0] brownout_level_fuse,
  input wire logic [1:0] startup_time_fuse,
  input wire logic [3:0] clock_select_fuse,
  input wire logic watchdog_always_on_fuse,
  // Bandgap requesters
  input wire logic comparator_bandgap_select,
  input wire logic adc_enable,
  // Watchdog control write
  input wire logic wdt_ctrl_we,
  input wire logic wr_watchdog_change_enable,
  input wire logic wr_watchdog_enable,
  input wire logic wr_watchdog_interrupt_enable,
  input wire logic wr_watchdog_interrupt_flag,
  input wire logic [3:0] wr_watchdog_prescale,
  input wire logic watchdog_clear_instruction,
  input wire logic watchdog_int_ack,
  // Reset status write
  input wire logic status_we,
  input wire logic [3:0] status_wr,
  // Reset outputs
  output logic core_reset,
  output logic io_port_reset,
  // Analog controls
  output logic bandgap_enable,
  output logic [2:0] brownout_level_select,
  // Watchdog readback
  output logic watchdog_enable,
  output logic watchdog_change_enable,
  output logic watchdog_interrupt_enable,
  output logic watchdog_interrupt_flag,
  output logic [3:0] watchdog_prescale,
  output logic watchdog_irq,
  // Reset cause flags
  output logic [3:0] reset_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and filters

  localparam int NSYNC = 16;

  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] pin_s;
  logic por_s, rst_pin_n_s, ext_en_s, below_s, above_s, osc_s, level2;
  // Synchronised fuse levels
  logic [2:0] bo_lvl_s;
  logic [1:0] stf_s;
  logic [3:0] csf_s;
  // Filtered pin and supply-dip levels
  logic ext_filt, bo_filt;

  assign pin_raw = {supply_below_por, reset_pin_n, ext_reset_enable, vcc_below_bot_minus,
                    vcc_above_bot_plus, wdt_osc_clk, brownout_level_fuse, startup_time_fuse,
                    clock_select_fuse, watchdog_always_on_fuse};

  srw_sync #(.W(NSYNC)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .d(pin_raw),
    .q(pin_s)
  );

  // Split the synchronised vector, same order as the packing above
  assign {por_s, rst_pin_n_s, ext_en_s, below_s, above_s, osc_s, bo_lvl_s, stf_s, csf_s,
          level2} = pin_s;

  // Pin low for the minimum width
  srw_filter #(.MIN_CYC(EXT_MIN_CYC), .W(16)) u_ext_filt (
    .core_clk(core_clk),
    .reset(reset),
    .lvl(ext_en_s & ~rst_pin_n_s),
    .filt(ext_filt)
  );

  // Supply dip for the minimum detection time
  // Short dips never reach the hysteresis latch
  srw_filter #(.MIN_CYC(BO_MIN_CYC), .W(16)) u_bo_filt (
    .core_clk(core_clk),
    .reset(reset),
    .lvl(below_s),
    .filt(bo_filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic rst_act;
    logic [DLY_W-1:0] dly;
    logic brown;
    logic osc_d;
    logic [WDT_W-1:0] wcnt;
    logic wpulse;
    logic en_b;
    logic ie_b;
    logic wdif;
    logic [3:0] wdp;
    logic ce_b;
    logic [2:0] ce_cnt;
    logic [3:0] flags;
    logic bg;
  } srw_state_t;

  srw_state_t s_r, s_nxt;

  logic bo_en, por_src, ext_src, bo_src, any_src, tick, wde_eff, run;
  logic [DLY_W-1:0] dly_len;
  logic [3:0] psel;
  logic [WDT_W:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  // Source decode and period selection

  always_comb begin
    bo_en = bo_lvl_s != BO_LEVEL_OFF;
    por_src = por_s;
    ext_src = ext_filt;
    bo_src = bo_en & s_r.brown;
    // Watchdog pulse joins the OR so its falling edge starts the delay
    any_src = por_src | ext_src | bo_src | s_r.wpulse;
    tick = osc_s & ~s_r.osc_d;
    // Delay length from start-up and clock fuses
    dly_len = (DLY_W'(DLY_UNIT) << stf_s) + (csf_s[3] ? DLY_W'(DLY_UNIT) : DLY_W'(0));
    // Level 2 or a pending watchdog flag keeps the enable set
    wde_eff = level2 | s_r.en_b | s_r.flags[FLG_WDOG];
    run = wde_eff | s_r.ie_b;
    psel = (s_r.wdp > WDT_PSEL_MAX) ? WDT_PSEL_MAX : s_r.wdp;
    limit = ((WDT_W + 1)'(WDT_BASE) << psel) - (WDT_W + 1)'(1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.osc_d = osc_s;
    s_nxt.wpulse = 1'b0;
    s_nxt.bg = bo_en | comparator_bandgap_select | adc_enable;

    // Hysteresis latch between lower and upper trigger
    if (bo_filt) begin
      s_nxt.brown = 1'b1;
    end else if (above_s) begin
      s_nxt.brown = 1'b0;
    end

    // Reset stretch, restarted by any active source
    if (any_src) begin
      s_nxt.rst_act = 1'b1;
      s_nxt.dly = '0;
    end else if (s_r.rst_act) begin
      if (s_r.dly >= dly_len - DLY_W'(1)) begin
        s_nxt.rst_act = 1'b0;
      end else begin
        s_nxt.dly = s_r.dly + DLY_W'(1);
      end
    end

    // Change-enable window
    if (s_r.ce_b) begin
      if (s_r.ce_cnt == 3'(CE_WINDOW_CYC - 1)) begin
        s_nxt.ce_b = 1'b0;
      end else begin
        s_nxt.ce_cnt = s_r.ce_cnt + 3'h1;
      end
    end

    // Interrupt vector taken
    if (watchdog_int_ack) begin
      s_nxt.wdif = 1'b0;
    end

    // Control write
    if (wdt_ctrl_we) begin
      s_nxt.ie_b = wr_watchdog_interrupt_enable;
      if (wr_watchdog_interrupt_flag) begin
        s_nxt.wdif = 1'b0;
      end
      if (wr_watchdog_enable) begin
        s_nxt.en_b = 1'b1;
      end else if (s_r.ce_b && !level2 && !s_r.flags[FLG_WDOG]) begin
        s_nxt.en_b = 1'b0;
      end
      // Level 2 takes a new period only inside the window
      if (!level2 || s_r.ce_b) begin
        s_nxt.wdp = wr_watchdog_prescale;
      end
      if (wr_watchdog_change_enable && wr_watchdog_enable) begin
        s_nxt.ce_b = 1'b1;
        s_nxt.ce_cnt = 3'h0;
      end else if (!wr_watchdog_change_enable) begin
        s_nxt.ce_b = 1'b0;
      end
    end

    // Watchdog counter and time-out action
    if (!run || watchdog_clear_instruction || s_r.rst_act) begin
      s_nxt.wcnt = '0;
    end else if (tick) begin
      if ({1'b0, s_r.wcnt} >= limit) begin
        s_nxt.wcnt = '0;
        if (s_r.ie_b) begin
          s_nxt.wdif = 1'b1;
          // Next time-out resets unless software re-arms
          if (wde_eff) begin
            s_nxt.ie_b = 1'b0;
          end
        end else begin
          s_nxt.wpulse = 1'b1;
        end
      end else begin
        s_nxt.wcnt = s_r.wcnt + WDT_W'(1);
      end
    end

    // Cause flags: zero write clears, new cause wins
    if (status_we) begin
      s_nxt.flags = s_r.flags & status_wr;
    end
    if (por_src) begin
      s_nxt.flags = FLAGS_RST;
    end else begin
      if (ext_src) begin
        s_nxt.flags[FLG_EXTRF] = 1'b1;
      end
      if (bo_src) begin
        s_nxt.flags[FLG_BORF] = 1'b1;
      end
      if (s_r.wpulse) begin
        s_nxt.flags[FLG_WDOG] = 1'b1;
      end
    end

    // Control bits take initial values during chip reset
    if (s_r.rst_act) begin
      s_nxt.en_b = 1'b0;
      s_nxt.ie_b = 1'b0;
      s_nxt.wdif = 1'b0;
      s_nxt.ce_b = 1'b0;
      s_nxt.ce_cnt = 3'h0;
      s_nxt.wdp = 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.rst_act <= 1'b1;
      s_r.flags <= FLAGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Clockless path straight from the detector pins
  assign io_port_reset = supply_below_por | (ext_reset_enable & ~reset_pin_n)
                         | ((brownout_level_fuse != BO_LEVEL_OFF) & vcc_below_bot_minus)
                         | s_r.rst_act;

  assign core_reset = s_r.rst_act;
  assign bandgap_enable = s_r.bg;
  assign brownout_level_select = bo_lvl_s;
  assign watchdog_enable = wde_eff;
  assign watchdog_change_enable = s_r.ce_b;
  assign watchdog_interrupt_enable = s_r.ie_b;
  assign watchdog_interrupt_flag = s_r.wdif;
  assign watchdog_prescale = s_r.wdp;
  assign watchdog_irq = s_r.wdif;
  assign reset_flags = s_r.flags;

endmodule // srw_reset_ctrl

// *** bench/srw_props.sv ***
// Port checker for the reset and watchdog block.
// Assumes one clock domain; bound to srw_reset_ctrl after the module.
module srw_props #(
  parameter int DLY_UNIT = 64
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Watched inputs
  input wire logic supply_below_por,
  input wire logic reset_pin_n,
  input wire logic wdt_ctrl_we,
  input wire logic watchdog_always_on_fuse,
  input wire logic comparator_bandgap_select,
  input wire logic adc_enable,
  input wire logic [2:0] brownout_level_fuse,
  // Watched outputs
  input wire logic core_reset,
  input wire logic io_port_reset,
  input wire logic bandgap_enable,
  input wire logic watchdog_enable,
  input wire logic watchdog_change_enable,
  input wire logic watchdog_interrupt_enable,
  input wire logic watchdog_irq,
  input wire logic [3:0] reset_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] idle_cnt_r;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Cycles since power-on or pin last active
  always_ff @(posedge core_clk) begin
    if (reset || supply_below_por || !reset_pin_n) begin
      idle_cnt_r <= 8'h00;
    end else if (idle_cnt_r != 8'hFF) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end
  // Window opened and left alone
  sequence win_open;
    $rose(watchdog_change_enable) ##0 (!wdt_ctrl_we) [*4];
  endsequence
  ////////////////////////////////////////////////////////////
  a_por_port_reset: assert property (supply_below_por |-> io_port_reset)
    else $error("port reset missing under power-on");
  a_core_port_reset: assert property (core_reset |-> io_port_reset)
    else $error("port reset missing under core reset");
  a_por_reassert: assert property ($rose(supply_below_por) |-> ##[1:3] core_reset)
    else $error("core reset late after supply drop");
  a_release_stretch: assert property ($fell(core_reset) |-> idle_cnt_r >= DLY_UNIT)
    else $error("core reset released too early");
  a_watchdog_reset_flag_keeps_en: assert property (reset_flags[3] |-> watchdog_enable)
    else $error("enable clear while watchdog flag set");
  a_level_two_on: assert property (watchdog_always_on_fuse [*4] |-> watchdog_enable)
    else $error("watchdog off in level two");
  a_window_len: assert property (win_open |-> watchdog_change_enable ##1 !watchdog_change_enable)
    else $error("change window length wrong");
  a_bandgap_req: assert property ((comparator_bandgap_select || adc_enable) |=> bandgap_enable)
    else $error("bandgap off while requested");
  a_bandgap_off: assert property
    ((brownout_level_fuse == 3'h7 && !comparator_bandgap_select && !adc_enable) [*5] |-> !bandgap_enable)
    else $error("bandgap on with no requester");
  a_irq_drops_ie: assert property ($rose(watchdog_irq) && watchdog_enable |-> !watchdog_interrupt_enable)
    else $error("interrupt enable kept after time-out");
  a_watchdog_reset_flag_reset: assert property ($rose(reset_flags[3]) |-> core_reset)
    else $error("watchdog flag without core reset");
endmodule // srw_props

bind srw_reset_ctrl srw_props #(.DLY_UNIT(DLY_UNIT)) u_props (
  .core_clk(core_clk), .reset(reset), .supply_below_por(supply_below_por), .reset_pin_n(reset_pin_n),
  .wdt_ctrl_we(wdt_ctrl_we), .watchdog_always_on_fuse(watchdog_always_on_fuse), .adc_enable(adc_enable),
  .comparator_bandgap_select(comparator_bandgap_select), .brownout_level_fuse(brownout_level_fuse),
  .core_reset(core_reset), .io_port_reset(io_port_reset), .bandgap_enable(bandgap_enable),
  .watchdog_enable(watchdog_enable), .watchdog_change_enable(watchdog_change_enable),
  .watchdog_interrupt_enable(watchdog_interrupt_enable), .watchdog_irq(watchdog_irq),
  .reset_flags(reset_flags));

// *** bench/srw_core_model.sv ***
// Core-side model: takes the watchdog interrupt vector.
// Assumes core_clk; acts at the falling edge, promptly or slowly.
module srw_core_model (
  // Clock
  input wire logic core_clk,
  // Interrupt handshake
  input wire logic watchdog_irq,
  input wire logic slow,
  output logic watchdog_int_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial watchdog_int_ack = 1'b0;
  // Vector taken one or six cycles after the request
  always @(negedge core_clk) begin
    if (watchdog_irq === 1'b1) begin
      repeat (slow ? 6 : 1) @(negedge core_clk);
      watchdog_int_ack = 1'b1;
      @(negedge core_clk);
      watchdog_int_ack = 1'b0;
    end
  end
endmodule // srw_core_model

// *** bench/system_reset_and_watchdog_bench.sv ***
// Self-checking bench for the reset and watchdog block.
// Assumes shortened delay and watchdog base counts; inputs change at the falling edge.
module system_reset_and_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 4;
  logic core_clk, reset, por, pin_n, ext_en, below, above, wosc, cbs, adc, aon, we, wce, wen, wie, wif;
  logic cinst, sw_e, slow, ack, core_reset, io_port_reset, bandgap_enable, wd_en, wd_ce, wd_ie, wd_if, irq;
  logic [2:0] bfuse, bsel;
  logic [1:0] stf;
  logic [3:0] cks, wps, swr, wd_ps, flags;
  int n_mismatch, tests_run, n;
  int nn[4];
  srw_reset_ctrl #(.DLY_UNIT(D), .WDT_BASE(4)) uut (
    .core_clk(core_clk), .reset(reset), .supply_below_por(por), .reset_pin_n(pin_n), .ext_reset_enable(ext_en),
    .vcc_below_bot_minus(below), .vcc_above_bot_plus(above), .wdt_osc_clk(wosc), .brownout_level_fuse(bfuse),
    .startup_time_fuse(stf), .clock_select_fuse(cks), .watchdog_always_on_fuse(aon), .adc_enable(adc),
    .comparator_bandgap_select(cbs), .wdt_ctrl_we(we), .wr_watchdog_change_enable(wce), .wr_watchdog_enable(wen),
    .wr_watchdog_interrupt_enable(wie), .wr_watchdog_interrupt_flag(wif), .wr_watchdog_prescale(wps),
    .watchdog_clear_instruction(cinst), .watchdog_int_ack(ack), .status_we(sw_e), .status_wr(swr),
    .core_reset(core_reset), .io_port_reset(io_port_reset), .bandgap_enable(bandgap_enable),
    .brownout_level_select(bsel), .watchdog_enable(wd_en), .watchdog_change_enable(wd_ce),
    .watchdog_interrupt_enable(wd_ie), .watchdog_interrupt_flag(wd_if), .watchdog_prescale(wd_ps),
    .watchdog_irq(irq), .reset_flags(flags));
  srw_core_model u_core (.core_clk(core_clk), .watchdog_irq(irq), .slow(slow), .watchdog_int_ack(ack));
  // Core clock and free-running watchdog oscillator
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    wosc = 1'b0;
    forever #3906 wosc = ~wosc;
  end
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wctl(input logic c, e, i, f, input logic [3:0] p);
    {wce, wen, wie, wif, wps} = {c, e, i, f, p};
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(1);
  endtask
  task automatic stat(input logic [3:0] v);
    swr = v;
    sw_e = 1'b1;
    cyc(1);
    sw_e = 1'b0;
    cyc(1);
  endtask
  task automatic wait_for(input bit sel_irq, input logic v, input int mx, output int k);
    k = 0;
    while ((sel_irq ? irq : core_reset) !== v && k < mx) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict;
  end
  // Main sequence
  initial begin
    {por, below, cbs, adc, aon, we, wce, wen, wie, wif, cinst, sw_e, slow} = '0;
    {reset, pin_n, ext_en, above} = 4'hF;
    {bfuse, stf, cks, wps, swr} = {3'h7, 2'h0, 4'h0, 4'h0, 4'h0};
    n_mismatch = 0;
    tests_run = 0;
    cyc(3);
    reset = 1'b0;
    wait_for(0, 1'b0, 200, n);
    check(flags, 4'h1);
    check(wd_en, 1'b0);
    for (int i = 0; i < 4; i++) begin
      stf = i[1:0];
      cks = (i == 2) ? 4'h8 : 4'h0;
      cyc(4);
      por = 1'b1;
      #1;
      check(io_port_reset, 1'b1);
      cyc(3);
      por = 1'b0;
      wait_for(0, 1'b0, 200, nn[i]);
      check(nn[i] - nn[0], (D << i) + ((i == 2) ? D : 0) - D);
    end
    check(nn[0] >= D && nn[0] <= D + 4, 1'b1);
    {stf, cks} = 6'h00;
    cyc(4);
    por = 1'b1;
    cyc(2);
    por = 1'b0;
    cyc(2);
    por = 1'b1;
    cyc(1);
    por = 1'b0;
    wait_for(0, 1'b0, 200, n);
    check(n, nn[0]);
    stat(4'h0);
    check(flags, 4'h0);
    pin_n = 1'b0;
    cyc(100);
    pin_n = 1'b1;
    cyc(10);
    check(core_reset, 1'b0);
    pin_n = 1'b0;
    cyc(260);
    check(core_reset, 1'b1);
    pin_n = 1'b1;
    wait_for(0, 1'b0, 200, n);
    check(n >= D && n <= D + 4, 1'b1);
    check(flags, 4'h2);
    stat(4'h0);
    bfuse = 3'h4;
    above = 1'b0;
    cyc(5);
    check(bsel, 3'h4);
    below = 1'b1;
    cyc(100);
    below = 1'b0;
    cyc(5);
    check(core_reset, 1'b0);
    below = 1'b1;
    cyc(210);
    check(core_reset, 1'b1);
    below = 1'b0;
    cyc(20);
    check(core_reset, 1'b1);
    above = 1'b1;
    wait_for(0, 1'b0, 200, n);
    check(n >= D && n <= D + 4, 1'b1);
    check(flags, 4'h4);
    bfuse = 3'h7;
    stat(4'h0);
    for (int i = 0; i < 3; i++) begin
      {adc, cbs} = i[1:0];
      cyc(5);
      check(bandgap_enable, i != 0);
    end
    {adc, cbs} = 2'h0;
    for (int p = 0; p < 2; p++) begin
      wctl(0, 1, 0, 0, p[3:0]);
      check(wd_ps, p);
      wait_for(0, 1'b1, 8000, n);
      check(n >= ((4 << p) - 1) * 781 && n <= (4 << p) * 782 + 20, 1'b1);
      cyc(2);
      check(flags[3], 1'b1);
      check(wd_en, 1'b1);
      wait_for(0, 1'b0, 200, n);
      check(n <= D + 4, 1'b1);
      stat(4'h0);
      check(wd_en, 1'b0);
    end
    wctl(0, 1, 0, 0, 4'h0);
    repeat (8) begin
      cyc(1000);
      cinst = 1'b1;
      cyc(1);
      cinst = 1'b0;
    end
    check(core_reset, 1'b0);
    wctl(0, 0, 0, 0, 4'h0);
    check(wd_en, 1'b1);
    wctl(1, 1, 0, 0, 4'h0);
    check(wd_ce, 1'b1);
    wctl(0, 0, 0, 0, 4'h0);
    check(wd_en, 1'b0);
    for (int m = 0; m < 2; m++) begin
      slow = m[0];
      wctl(0, m[0], 1, 0, 4'h0);
      wait_for(1, 1'b1, 4000, n);
      check(wd_if, 1'b1);
      check(wd_ie, !m[0]);
      check(core_reset, 1'b0);
      cyc(10);
      check(irq, 1'b0);
    end
    wait_for(0, 1'b1, 4000, n);
    check(core_reset, 1'b1);
    wait_for(0, 1'b0, 200, n);
    stat(4'h0);
    aon = 1'b1;
    cyc(4);
    check(wd_en, 1'b1);
    wctl(1, 1, 0, 0, 4'h0);
    wctl(0, 0, 0, 0, 4'h0);
    check(wd_en, 1'b1);
    wctl(0, 1, 0, 0, 4'h2);
    check(wd_ps, 4'h0);
    wctl(1, 1, 0, 0, 4'h0);
    cyc(6);
    check(wd_ce, 1'b0);
    wctl(1, 1, 0, 0, 4'h0);
    wctl(0, 1, 0, 0, 4'h2);
    check(wd_ps, 4'h2);
    give_verdict;
  end
endmodule // system_reset_and_watchdog_bench
